/* rtl/ps_host_pkg.sv */
/*
 * Constants for the passive serial configuration host: timing in its own
 * units, derived cycle counts at the 100 MHz system clock, and the states.
 * Assumes a single 100 MHz clock; every derived count uses CLK_PERIOD_NS.
 */
package ps_host_pkg;

   // System clock
   localparam int CLK_PERIOD_NS       = 10;

   // Configuration-request low pulse, least time, rounded up
   localparam int CFG_LOW_NS          = 2000;
   localparam int CFG_LOW_CYC         = (CFG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Auto-restart release timeout, longest time, rounded down
   localparam int RESTART_TIMEOUT_NS  = 40000;
   localparam int RESTART_TIMEOUT_CYC = RESTART_TIMEOUT_NS / CLK_PERIOD_NS;

   // Serial clock half period in system cycles (12.5 MHz serial clock)
   localparam int SCLK_HALF_CYC       = 4;
   // User start-up clock half period in system cycles (25 MHz, under 100 MHz)
   localparam int UCLK_HALF_CYC       = 2;
   // Start-up clock cycles the device needs after the done line rises
   localparam int USER_INIT_CYCLES    = 299;

   // Filler bytes clocked after the last byte before giving up on done
   localparam int FLUSH_LIMIT_BYTES   = 64;

   // Widths
   localparam int TMR_W               = 24;
   localparam int UEDGE_W             = 9;
   localparam int ERRCNT_W            = 8;

   // Values after reset
   localparam logic [TMR_W-1:0]    TMR_RST    = 24'h000000;
   localparam logic [ERRCNT_W-1:0] ERRCNT_RST = 8'h00;

   // Host sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_PULSE    = 8'h02,
      ST_WAITSTAT = 8'h04,
      ST_LOAD     = 8'h08,
      ST_FLUSH    = 8'h10,
      ST_INIT     = 8'h20,
      ST_USER     = 8'h40,
      ST_RECOVER  = 8'h80
   } host_state_t;

endpackage : ps_host_pkg

/* rtl/cfg_shift_if.sv */
/*
 * Carrier between the host sequencer and its bit shifter.
 * Assumes both ends run on the same clock; no clocking block.
 */
`timescale 1ns/1ps
`default_nettype none

interface cfg_shift_if;
   logic       load;    // Take byteIn, one-cycle pulse, only while idle
   logic       abort;   // Stop and park the serial lines low
   logic [7:0] byteIn;  // Byte to shift, LSB first
   logic       idle;    // Shifter free for the next byte
   logic       sclk;    // Serial clock to the pin
   logic       sdata;   // Serial data to the pin

   modport ctrl    (output load, output abort, output byteIn,
                    input idle, input sclk, input sdata);
   modport shifter (input load, input abort, input byteIn,
                    output idle, output sclk, output sdata);
endinterface : cfg_shift_if

`default_nettype wire

/* rtl/cfg_bit_shifter.sv */
/*
 * Serialises one byte at a time onto the serial clock and data lines,
 * least significant bit first; data changes only while the clock is low.
 * Assumes load arrives only while idle is high and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_bit_shifter
   import ps_host_pkg::*;
(
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    srst,
   // Sequencer side
   cfg_shift_if.shifter sh
);

   localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);

   logic [7:0] shift_reg;
   logic [2:0] bitsLeft_reg;
   logic [2:0] halfCnt_reg;

   // Bit engine: low half with data set up, then rising edge, then shift
   always_ff @(posedge clk) begin
      if (srst) begin
         sh.idle      <= 1'b1;
         sh.sclk      <= 1'b0;
         sh.sdata     <= 1'b0;
         shift_reg    <= 8'h00;
         bitsLeft_reg <= 3'h0;
         halfCnt_reg  <= 3'h0;
      end else if (sh.abort) begin
         sh.idle  <= 1'b1;  // Lines parked at a fixed level
         sh.sclk  <= 1'b0;
         sh.sdata <= 1'b0;
      end else if (sh.idle && sh.load) begin
         shift_reg    <= sh.byteIn;
         sh.sdata     <= sh.byteIn[0];
         bitsLeft_reg <= 3'h7;
         halfCnt_reg  <= HALF_LAST;
         sh.idle      <= 1'b0;
         sh.sclk      <= 1'b0;
      end else if (!sh.idle) begin
         if (halfCnt_reg != 3'h0) begin
            halfCnt_reg <= halfCnt_reg - 3'h1;
         end else begin
            halfCnt_reg <= HALF_LAST;
            if (!sh.sclk) begin
               sh.sclk <= 1'b1;
            end else begin
               sh.sclk <= 1'b0;
               if (bitsLeft_reg == 3'h0) begin
                  sh.idle <= 1'b1;
               end else begin
                  shift_reg    <= shift_reg >> 1;
                  sh.sdata     <= shift_reg[1];
                  bitsLeft_reg <= bitsLeft_reg - 3'h1;
               end
            end
         end
      end
   end

endmodule : cfg_bit_shifter

`default_nettype wire

/* rtl/ps_config_host.sv */
/*
 * Host controller that loads a bitstream into a device over its passive
 * serial configuration port, restarts on error, and reports user mode.
 * Assumes open-drain status, done and init lines have board pull-ups and
 * that the byte source restarts from its first byte on sourceRewind.
 */
`timescale 1ns/1ps
`default_nettype none

module ps_config_host
   import ps_host_pkg::*;
#(
   parameter int DONE_TO_USER_CYC = 10000,   // Done-to-user wait without init output
   parameter int INIT_TIMEOUT_CYC = 100000   // Longest wait for init output rise
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // Options, held steady while busy
   input  wire logic                useInitDone,
   input  wire logic                useUserClock,
   input  wire logic                autoRestart,
   // Control and status
   input  wire logic                startReq,
   output logic                     busy,
   output logic                     userMode,
   output logic [ERRCNT_W-1:0]      errorCount,
   // Bitstream byte source
   input  wire logic [7:0]          byteData,
   input  wire logic                byteValid,
   input  wire logic                byteLast,
   output logic                     byteReady,
   output logic                     sourceRewind,
   // Device configuration pins
   output logic                     cfgRequestN,
   output logic                     serial_config_clock,
   output logic                     serial_config_data,
   output logic                     user_startup_clock,
   input  wire logic                statusLine,
   input  wire logic                load_complete,
   input  wire logic                initComplete
);

   cfg_shift_if sh ();

   host_state_t          st_reg, st_next;
   logic [TMR_W-1:0]     tmr_reg;
   logic [2:0]           syncA_reg, syncB_reg;
   logic                 statusS, doneS, initS;
   logic                 take, failNow, failToRecover;
   logic [7:0]           flushCnt_reg;
   logic                 initSeenLow_reg;
   logic [1:0]           ucDiv_reg;
   logic [UEDGE_W-1:0]   uEdges_reg;
   logic                 initEnough;

   cfg_bit_shifter u_shifter (
      .clk  (clk),
      .srst (srst),
      .sh   (sh)
   );

   // Two-stage sync of the device pins; only stage B is read
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_reg <= 3'h0;
         syncB_reg <= 3'h0;
      end else begin
         syncA_reg <= {initComplete, load_complete, statusLine};
         syncB_reg <= syncA_reg;
      end
   end
   assign statusS = syncB_reg[0];
   assign doneS   = syncB_reg[1];
   assign initS   = syncB_reg[2];

   // Byte hand-off and filler bytes while waiting on done
   assign take      = byteValid && byteReady;
   assign sh.load   = take || (st_reg == ST_FLUSH && sh.idle);
   assign sh.byteIn = (st_reg == ST_FLUSH) ? 8'h00 : byteData;
   assign sh.abort  = (st_next != ST_LOAD) && (st_next != ST_FLUSH);

   // Initialization finished when no init output is used
   assign initEnough = (tmr_reg >= TMR_W'(DONE_TO_USER_CYC))
                     && (!useUserClock || uEdges_reg >= UEDGE_W'(USER_INIT_CYCLES));

   // Next state
   always_comb begin
      st_next       = st_reg;
      failNow       = 1'b0;
      failToRecover = 1'b0;
      unique case (st_reg)
         ST_IDLE: begin
            if (startReq) st_next = ST_PULSE;
         end
         ST_PULSE: begin
            if (tmr_reg >= TMR_W'(CFG_LOW_CYC - 1)) st_next = ST_WAITSTAT;
         end
         ST_WAITSTAT: begin
            if (statusS) st_next = ST_LOAD;
         end
         ST_LOAD: begin
            if (!statusS) failNow = 1'b1;
            else if (doneS) st_next = ST_INIT;
            else if (take && byteLast) st_next = ST_FLUSH;
         end
         ST_FLUSH: begin
            if (!statusS) failNow = 1'b1;
            else if (doneS) st_next = ST_INIT;
            else if (flushCnt_reg >= 8'(FLUSH_LIMIT_BYTES)) failNow = 1'b1;
         end
         ST_INIT: begin
            if (!statusS) failNow = 1'b1;
            else if (useInitDone && initSeenLow_reg && initS) st_next = ST_USER;
            else if (useInitDone && tmr_reg >= TMR_W'(INIT_TIMEOUT_CYC)) failNow = 1'b1;
            else if (!useInitDone && initEnough) st_next = ST_USER;
         end
         ST_USER: begin
            if (startReq) st_next = ST_PULSE;
         end
         ST_RECOVER: begin
            if (statusS) st_next = ST_LOAD;
            else if (tmr_reg >= TMR_W'(RESTART_TIMEOUT_CYC)) st_next = ST_PULSE;
         end
      endcase
      if (failNow) begin
         failToRecover = autoRestart && !statusS;
         st_next = failToRecover ? ST_RECOVER : ST_PULSE;
      end
   end

   // State and per-state timer
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg  <= ST_IDLE;
         tmr_reg <= TMR_RST;
      end else begin
         st_reg  <= st_next;
         if (st_next != st_reg) tmr_reg <= TMR_RST;
         else if (tmr_reg != {TMR_W{1'b1}}) tmr_reg <= tmr_reg + TMR_W'(1);
      end
   end

   // Filler byte count; done must rise within a bounded tail
   always_ff @(posedge clk) begin
      if (srst) flushCnt_reg <= 8'h00;
      else if (st_reg != ST_FLUSH) flushCnt_reg <= 8'h00;
      else if (sh.load && flushCnt_reg != 8'hff) flushCnt_reg <= flushCnt_reg + 8'h01;
   end

   // Init output must be seen low before its rise counts
   always_ff @(posedge clk) begin
      if (srst) initSeenLow_reg <= 1'b0;
      else if (st_reg == ST_PULSE || st_reg == ST_RECOVER) initSeenLow_reg <= 1'b0;
      else if (!initS && (st_reg == ST_LOAD || st_reg == ST_FLUSH || st_reg == ST_INIT))
         initSeenLow_reg <= 1'b1;
   end

   // Free-running start-up clock; never stopped, so restarts see it toggle
   always_ff @(posedge clk) begin
      if (srst) begin
         ucDiv_reg          <= 2'h0;
         user_startup_clock <= 1'b0;
      end else if (!useUserClock) begin
         ucDiv_reg          <= 2'h0;
         user_startup_clock <= 1'b0;
      end else if (ucDiv_reg == 2'(UCLK_HALF_CYC - 1)) begin
         ucDiv_reg          <= 2'h0;
         user_startup_clock <= ~user_startup_clock;
      end else begin
         ucDiv_reg <= ucDiv_reg + 2'h1;
      end
   end

   // Start-up clock rises counted from the done rise
   always_ff @(posedge clk) begin
      if (srst) uEdges_reg <= '0;
      else if (st_reg != ST_INIT) uEdges_reg <= '0;
      else if (useUserClock && ucDiv_reg == 2'(UCLK_HALF_CYC - 1) && !user_startup_clock
               && uEdges_reg != {UEDGE_W{1'b1}})
         uEdges_reg <= uEdges_reg + UEDGE_W'(1);
   end

   // Request pin low in idle and during the reconfigure pulse only
   always_ff @(posedge clk) begin
      if (srst) cfgRequestN <= 1'b0;
      else cfgRequestN <= !(st_next == ST_IDLE || st_next == ST_PULSE);
   end

   // Byte source handshake; rewind on every new pass over the bitstream
   always_ff @(posedge clk) begin
      if (srst) begin
         byteReady    <= 1'b0;
         sourceRewind <= 1'b0;
      end else begin
         byteReady    <= (st_reg == ST_LOAD) && (st_next == ST_LOAD) && sh.idle && !take;
         sourceRewind <= (st_next == ST_LOAD) && (st_reg != ST_LOAD);
      end
   end

   // Status outputs and error tally
   always_ff @(posedge clk) begin
      if (srst) begin
         busy       <= 1'b0;
         userMode   <= 1'b0;
         errorCount <= ERRCNT_RST;
      end else begin
         busy     <= !(st_next == ST_IDLE || st_next == ST_USER);
         userMode <= (st_next == ST_USER);
         if (failNow && errorCount != {ERRCNT_W{1'b1}})
            errorCount <= errorCount + ERRCNT_W'(1);
      end
   end

   // Serial lines come from the shifter flops; the done line is input only
   assign serial_config_clock = sh.sclk;
   assign serial_config_data  = sh.sdata;

endmodule : ps_config_host

`default_nettype wire

/* bench/ps_host_assertions.sv */
/* Port checker for the configuration host.
   Assumes one clk domain with synchronous srst. */
`timescale 1ns/1ps
`default_nettype none
module ps_host_assertions
   import ps_host_pkg::*;
#(parameter int DONE_TO_USER_CYC = 10000, parameter int INIT_TIMEOUT_CYC = 100000) (
   // Control
   input wire logic clk, srst, useInitDone, useUserClock, autoRestart, startReq, busy,
   input wire logic userMode,
   input wire logic [ERRCNT_W-1:0] errorCount,
   // Byte source
   input wire logic [7:0] byteData,
   input wire logic byteValid, byteLast, byteReady, sourceRewind,
   // Device pins
   input wire logic cfgRequestN, serial_config_clock, serial_config_data, user_startup_clock,
   input wire logic statusLine, load_complete, initComplete
);
   logic [15:0] lowCnt; // Saturates, idle lows are long
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Request-low run length
   always_ff @(posedge clk) begin
      if (srst || cfgRequestN) lowCnt <= 16'h0000;
      else if (lowCnt != 16'hffff) lowCnt <= lowCnt + 16'h0001;
   end
   reset_values_a: assert property ($fell(srst) |-> !cfgRequestN && !busy && !userMode
      && errorCount == 8'h00 && !byteReady) else $error("Bad state after reset");
   start_answer_a: assert property (startReq && !busy |=> busy && !cfgRequestN)
      else $error("Start not answered");
   request_pulse_a: assert property ($rose(cfgRequestN) |-> lowCnt >= 16'd200)
      else $error("Request pulse too short");
   sclk_low_a: assert property ($fell(serial_config_clock) |=> !serial_config_clock [*3])
      else $error("Serial clock low too short");
   sclk_high_a: assert property ($rose(serial_config_clock) |-> ##4 !serial_config_clock)
      else $error("Serial clock high wrong");
   data_stable_a: assert property (serial_config_clock |-> $stable(serial_config_data))
      else $error("Data moved while clock high");
   byte_take_a: assert property (byteValid && byteReady |=> !byteReady)
      else $error("Ready held after take");
   status_drop_a: assert property (!statusLine [*6] |-> !byteReady)
      else $error("Ready kept while status low");
   user_park_a: assert property (userMode |-> !serial_config_clock && !serial_config_data)
      else $error("Serial lines not parked");
   user_clock_a: assert property ($rose(user_startup_clock)
      |=> user_startup_clock ##1 !user_startup_clock) else $error("User clock rate wrong");
   user_cov_c: cover property ($rose(userMode));
   error_cov_c: cover property (errorCount != $past(errorCount));
   rewind_cov_c: cover property (sourceRewind);
endmodule : ps_host_assertions
bind ps_config_host ps_host_assertions #(.DONE_TO_USER_CYC(DONE_TO_USER_CYC),
   .INIT_TIMEOUT_CYC(INIT_TIMEOUT_CYC)) chk_u (.clk(clk), .srst(srst),
   .useInitDone(useInitDone), .useUserClock(useUserClock), .autoRestart(autoRestart),
   .startReq(startReq), .busy(busy), .userMode(userMode), .errorCount(errorCount),
   .byteData(byteData), .byteValid(byteValid), .byteLast(byteLast), .byteReady(byteReady),
   .sourceRewind(sourceRewind), .cfgRequestN(cfgRequestN),
   .serial_config_clock(serial_config_clock), .serial_config_data(serial_config_data),
   .user_startup_clock(user_startup_clock), .statusLine(statusLine),
   .load_complete(load_complete), .initComplete(initComplete));
`default_nettype wire

/* bench/ps_device_model.sv */
/* Behavioural model of the configured device on its serial port.
   Assumes pulled-up open-drain lines, shown here as plain levels. */
`timescale 1ns/1ps
`default_nettype none
module ps_device_model
   import ps_host_pkg::*;
#(parameter int NBYTES = 6, parameter int OSC_INIT = 30, parameter int RESTART_DLY = 500) (
   // Clock, power-on and pins
   input wire logic clk, srst, cfgRequestN, serial_config_clock, serial_config_data,
   input wire logic user_startup_clock,
   output logic statusLine, load_complete, initComplete,
   // Scenario control
   input wire logic useInitDone, useUserClock, autoRestart,
   input wire logic [1:0] faultMode,
   output logic [7:0] badBytes
);
   logic [7:0] sh;
   logic [2:0] bitCnt;
   logic sclkPrev, uclkPrev, tried, stuck;
   int byteCnt, initCnt, errTmr, por;
   wire logic [7:0] rxByte = {serial_config_data, sh[7:1]};
   wire logic sRise = serial_config_clock && !sclkPrev && !load_complete;
   function automatic logic [7:0] pattern_byte(input int i);
      return 8'(i * 59 + 2);
   endfunction : pattern_byte
   // Power-on hold, short for simulation
   always_ff @(posedge clk) por <= srst ? 100 : (por != 0 ? por - 1 : 0);
   // Reset, load, error and start-up stages
   always_ff @(posedge clk) begin
      sclkPrev <= serial_config_clock;
      uclkPrev <= user_startup_clock;
      if (srst || !cfgRequestN || por != 0) begin
         statusLine <= 1'b0;
         load_complete <= 1'b0;
         initComplete <= 1'b1;
         bitCnt <= 3'h0;
         byteCnt <= 0;
         errTmr <= 0;
         initCnt <= 0;
         stuck <= 1'b0;
         if (srst) begin
            tried <= 1'b0;
            badBytes <= 8'h00;
         end
      end else if (errTmr != 0) begin
         statusLine <= autoRestart && errTmr == 1;
         if (autoRestart) errTmr <= errTmr - 1;
      end else begin
         statusLine <= 1'b1;
         if (sRise) begin
            sh <= rxByte;
            bitCnt <= bitCnt + 3'h1;
         end
         if (sRise && bitCnt == 3'h7) begin
            byteCnt <= byteCnt + 1;
            if (byteCnt < NBYTES && rxByte !== pattern_byte(byteCnt)) badBytes <= badBytes + 8'h01;
            if (byteCnt == 0 && useInitDone) initComplete <= 1'b0;
            if (byteCnt == NBYTES - 1 && faultMode[1]) tried <= 1'b1;
            stuck <= byteCnt == NBYTES - 1 && faultMode == 2'h2 && !tried;
            if (byteCnt == NBYTES - 1 && !(faultMode == 2'h3 && !tried)) load_complete <= 1'b1;
            if (faultMode == 2'h1 && !tried && byteCnt == 2) begin
               errTmr <= RESTART_DLY;
               statusLine <= 1'b0;
               bitCnt <= 3'h0;
               byteCnt <= 0;
               tried <= 1'b1;
            end
         end
         // Oscillator cycles, or rises of the start-up clock
         if (load_complete && !stuck && (!useUserClock || (user_startup_clock && !uclkPrev)))
            initCnt <= initCnt + 1;
         if (initCnt >= (useUserClock ? USER_INIT_CYCLES : OSC_INIT)) initComplete <= 1'b1;
      end
   end
endmodule : ps_device_model
`default_nettype wire

/* bench/tb_top.sv */
/* Self-checking bench: host against the device model, pattern byte source.
   Assumes the design package, the device model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ps_host_pkg::*;
   localparam int NBYTES = 6;
   // Options {initDone, userClock, autoRestart, fault} beside expected error count
   typedef struct packed {logic [4:0] opt; logic [7:0] expErr;} row_t;
   row_t rows [7] = '{'{5'b00000, 8'h00}, '{5'b10000, 8'h00}, '{5'b11000, 8'h00},
      '{5'b00101, 8'h01}, '{5'b00001, 8'h01}, '{5'b10010, 8'h01}, '{5'b00111, 8'h01}};
   logic clk = 1'b0, srst = 1'b1, startReq = 1'b0, useInitDone = 1'b0, useUserClock = 1'b0;
   logic autoRestart = 1'b0;
   logic [1:0] faultMode = 2'h0;
   logic busy, userMode, byteReady, sourceRewind, cfgRequestN, sclk, sdata, uclk;
   logic statusLine, loadDone, initComplete;
   logic [7:0] errorCount, badBytes;
   int idx = 0, errors = 0, n_compared = 0, cycles = 0, nRewind = 0, nUclk = 0;
   logic uclkPrev = 1'b0;
   function automatic logic [7:0] pattern_byte(input int i);
      return 8'(i * 59 + 2);
   endfunction : pattern_byte
   wire logic [7:0] byteData = pattern_byte(idx);
   wire logic byteValid = idx < NBYTES;
   wire logic byteLast = idx == NBYTES - 1;
   ps_config_host #(.DONE_TO_USER_CYC(50), .INIT_TIMEOUT_CYC(2000)) dut_u (
      .clk(clk), .srst(srst), .useInitDone(useInitDone), .useUserClock(useUserClock),
      .autoRestart(autoRestart), .startReq(startReq), .busy(busy), .userMode(userMode),
      .errorCount(errorCount), .byteData(byteData), .byteValid(byteValid),
      .byteLast(byteLast), .byteReady(byteReady), .sourceRewind(sourceRewind),
      .cfgRequestN(cfgRequestN), .serial_config_clock(sclk), .serial_config_data(sdata),
      .user_startup_clock(uclk), .statusLine(statusLine), .load_complete(loadDone),
      .initComplete(initComplete));
   ps_device_model #(.NBYTES(NBYTES)) dev_u (.clk(clk), .srst(srst),
      .cfgRequestN(cfgRequestN), .serial_config_clock(sclk), .serial_config_data(sdata),
      .user_startup_clock(uclk), .statusLine(statusLine), .load_complete(loadDone),
      .initComplete(initComplete), .useInitDone(useInitDone), .useUserClock(useUserClock),
      .autoRestart(autoRestart), .faultMode(faultMode), .badBytes(badBytes));
   always #5 clk = ~clk;
   // Byte source, restarts on rewind
   always @(posedge clk) idx <= #1 (srst || sourceRewind) ? 0 : idx + int'(byteValid && byteReady);
   // Rewind pulses and start-up clock rises per row, cleared by reset
   always @(posedge clk) begin
      if (srst) begin
         nRewind <= 0;
         nUclk   <= 0;
      end else begin
         nRewind <= nRewind + int'(sourceRewind);
         nUclk   <= nUclk + int'(uclk && !uclkPrev);
      end
      uclkPrev <= uclk;
   end
   // Hang guard, well above the longest run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic start();
      startReq = 1'b1;
      tick(1);
      startReq = 1'b0;
      tick(1);
   endtask : start
   task automatic wait_user();
      for (int k = 0; k < 20000 && userMode !== 1'b1; k++) tick(1);
   endtask : wait_user
   initial begin
      foreach (rows[i]) begin
         {useInitDone, useUserClock, autoRestart, faultMode} = rows[i].opt;
         srst = 1'b1;
         tick(8);
         srst = 1'b0;
         tick(1);
         check(cfgRequestN, 8'h00);
         start();
         check(busy, 8'h01);
         wait_user();
         check(userMode, 8'h01);
         check(errorCount, rows[i].expErr);
         check(badBytes, 8'h00);
         check({sclk, sdata}, 8'h00);
         check(8'(nRewind), 8'h01 + rows[i].expErr);
         check({7'h00, nUclk >= USER_INIT_CYCLES}, {7'h00, useUserClock});
      end
      // Reconfigure from user mode
      start();
      check({userMode, busy}, 8'h01);
      wait_user();
      check({userMode, errorCount[0]}, 8'h03);
      // Reset in mid-load
      start();
      tick(400);
      srst = 1'b1;
      tick(8);
      srst = 1'b0;
      tick(1);
      check({busy, userMode, cfgRequestN, byteReady}, 8'h00);
      check(errorCount, 8'h00);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
